// [src/ccp_defs.svh]
// constants of the clock conditioning and phase output stage
`ifndef CCP_DEFS_SVH
`define CCP_DEFS_SVH

`define CCP_PERIOD_W      16
`define CCP_RATIO_W       5
`define CCP_FINE_W        9
`define CCP_FINE_FRAC     8
`define CCP_FINE_MAX      255
`define CCP_FINE_FIXED    0
`define CCP_SYNTH_W       22

`endif

// [src/ccp_pkg.sv]
// types of the clock conditioning and phase output stage
package ccp_pkg;
    typedef enum logic [1:0] {CCP_MTR_IDLE, CCP_MTR_ARMED, CCP_MTR_RUN} ccp_meter_state_t;
    typedef logic signed [8:0] ccp_fine_t;
endpackage

// [src/ccp_period_meter.sv]
// input clock synchroniser and period / high time meter
`timescale 1ns/1ps
`include "ccp_defs.svh"
module ccp_period_meter #(
    parameter int PW = `CCP_PERIOD_W
) (
    input  wire logic          core_clk,
    input  wire logic          rst_n,
    input  wire logic          source_clock_in,
    output logic               rise_pulse,
    output logic [PW-1:0]      period,
    output logic [PW-1:0]      high_time,
    output logic               valid
);
    import ccp_pkg::*;

    logic             sync1_q;
    logic             sync2_q;
    logic             prev_q;
    logic             fall;
    ccp_meter_state_t st_q;
    ccp_meter_state_t st_d;
    logic [PW-1:0]    cnt_q;
    logic [PW-1:0]    cnt_d;
    logic [PW-1:0]    per_q;
    logic [PW-1:0]    per_d;
    logic [PW-1:0]    hi_q;
    logic [PW-1:0]    hi_d;

    assign rise_pulse = sync2_q & ~prev_q;
    assign fall       = ~sync2_q & prev_q;
    assign period     = per_q;
    assign high_time  = hi_q;
    assign valid      = (st_q == CCP_MTR_RUN);

    // ----------------------------------------
    // measurement
    // ----------------------------------------
    always_comb begin
        st_d  = st_q;
        per_d = per_q;
        hi_d  = hi_q;
        // saturate so a stopped input cannot wrap into a bogus short period
        cnt_d = (cnt_q == {PW{1'b1}}) ? cnt_q : cnt_q + {{(PW-1){1'b0}}, 1'b1};
        case (st_q)
            CCP_MTR_IDLE: begin
                if (rise_pulse) begin
                    st_d  = CCP_MTR_ARMED;
                    cnt_d = {{(PW-1){1'b0}}, 1'b1};
                end
            end
            CCP_MTR_ARMED, CCP_MTR_RUN: begin
                if (fall) begin
                    hi_d = cnt_q;
                end
                if (rise_pulse) begin
                    per_d = cnt_q;
                    cnt_d = {{(PW-1){1'b0}}, 1'b1};
                    st_d  = CCP_MTR_RUN;
                end
            end
            default: begin
                st_d = CCP_MTR_IDLE;
            end
        endcase
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
            st_q    <= CCP_MTR_IDLE;
            cnt_q   <= '0;
            per_q   <= '0;
            hi_q    <= '0;
        end else begin
            sync1_q <= source_clock_in;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
            st_q    <= st_d;
            cnt_q   <= cnt_d;
            per_q   <= per_d;
            hi_q    <= hi_d;
        end
    end
endmodule

// [src/ccp_clock_outputs.sv]
// derived clock output stage: quadrant, doubled, divided and synthesized outputs
// Operation
// - with duty correction on, the zero and three quadrant outputs are reshaped to 50% duty.
// - with duty correction off, the quadrant outputs follow the measured input high time.
// - quadrant outputs rise at 0, 90, 180 and 270 degrees of the input period.
// - in high frequency mode only the zero and half quadrant outputs run; quarter and three-quarter stay low.
// - each quadrant output lags the previous one by a quarter of the input period.
// - the zero output runs at the input rate and its companion is it delayed by half a period.
// - in low frequency mode the doubled pair runs at twice the input rate with 50% duty; in high mode both stay low.
// - the synthesized pair always has 50% duty at input rate times multiply over divide.
// - the divided output is 50% in low mode, and in high mode only for an integer ratio.
// - a fixed fine shift in 1/256 period steps, set at build time, moves all outputs together.
// - user logic may step the fine shift at run time in 1/256 period steps.
// - half-period, quadrant and fine shifts act independently and may combine.
// - the zero output rises at the period start and its half companion at mid period; the doubled companion rises a quarter period after the doubled output.
`timescale 1ns/1ps
`include "ccp_defs.svh"
module ccp_clock_outputs #(
    parameter int PW          = `CCP_PERIOD_W,
    parameter int FINE_FIXED  = `CCP_FINE_FIXED
) (
    input  wire logic                     core_clk,
    input  wire logic                     rst_n,
    input  wire logic                     source_clock_in,
    input  wire logic                     duty_correct_en,
    input  wire logic                     freq_mode_high,
    input  wire logic [`CCP_RATIO_W-1:0]  divider_ratio,
    input  wire logic [`CCP_RATIO_W-1:0]  synth_mult,
    input  wire logic [`CCP_RATIO_W-1:0]  synth_div,
    input  wire logic                     fine_step_req,
    input  wire logic                     fine_step_inc,
    output logic                          deskewed_out_phase_zero,
    output logic                          quadrant_out_quarter,
    output logic                          quadrant_out_half,
    output logic                          quadrant_out_three_quarter,
    output logic                          doubled_out,
    output logic                          doubled_out_inverted_phase,
    output logic                          divided_out,
    output logic                          synth_out,
    output logic                          synth_out_inverted_phase,
    output ccp_pkg::ccp_fine_t            fine_shift_value,
    output logic                          measure_valid
);
    import ccp_pkg::*;

    localparam int SW = `CCP_SYNTH_W;
    localparam int RW = `CCP_RATIO_W;

    logic            rise;
    logic            valid;
    logic [PW-1:0]   per;
    logic [PW-1:0]   hi_time;
    logic [PW-1:0]   half;
    logic [PW-1:0]   qtr;
    logic [PW-1:0]   tqtr;
    logic [PW-1:0]   shift;
    logic [PW-1:0]   eff;
    logic [PW-1:0]   eff2;
    logic [PW-1:0]   lim;
    logic [PW+7:0]   shift_prod;
    logic [7:0]      fine_mag;
    logic [RW:0]     ratio_q4;
    logic [RW:0]     div_lim;
    logic [RW-1:0]   mult;
    logic [RW-1:0]   dvs;
    logic [SW-1:0]   synth_len;
    logic [SW-1:0]   acc_sum;
    logic            qtick;

    logic [PW-1:0]   phase_q, phase_d;
    logic [RW:0]     qcnt_q, qcnt_d;
    logic [RW-1:0]   pcnt_q, pcnt_d;
    logic [SW-1:0]   acc_q, acc_d;
    ccp_fine_t       fine_q, fine_d;
    logic [8:0]      outs_q, outs_d;
    logic            valid_q;

    ccp_period_meter #(.PW(PW)) u_meter (
        .core_clk        (core_clk),
        .rst_n           (rst_n),
        .source_clock_in (source_clock_in),
        .rise_pulse      (rise),
        .period          (per),
        .high_time       (hi_time),
        .valid           (valid)
    );

    // distance from b forward to a, modulo m (b below m assumed)
    function automatic logic [PW-1:0] sub_mod(input logic [PW-1:0] a, input logic [PW-1:0] b,
                                              input logic [PW-1:0] m);
        logic [PW:0] t;
        t = (a >= b) ? {1'b0, a} - {1'b0, b} : {1'b0, a} + {1'b0, m} - {1'b0, b};
        return t[PW-1:0];
    endfunction

    // ----------------------------------------
    // phase arithmetic
    // ----------------------------------------
    assign half       = per >> 1;
    assign qtr        = per >> 2;
    assign tqtr       = half + qtr;
    assign fine_mag   = fine_q[8] ? 8'(-fine_q) : fine_q[7:0];
    assign shift_prod = per * fine_mag;
    assign shift      = shift_prod[PW+7:8];
    // fine shift is applied once to the shared phase, so every output moves with it
    assign eff        = fine_q[8] ? sub_mod(phase_q, per - shift, per) : sub_mod(phase_q, shift, per);
    assign eff2       = (eff >= half) ? eff - half : eff;
    assign lim        = duty_correct_en ? half : hi_time;
    assign qtick      = valid && (eff == '0 || eff == qtr || eff == half || eff == tqtr);
    assign mult       = (synth_mult == '0) ? RW'(1) : synth_mult;
    assign dvs        = (synth_div == '0) ? RW'(1) : synth_div;
    assign synth_len  = SW'(per) * SW'(dvs);
    assign acc_sum    = acc_q + SW'(mult);
    // ratio in half steps, held at 1.0 or more; output period in quarter input periods is twice it
    assign ratio_q4   = (divider_ratio < RW'(2)) ? (RW+1)'(4) : {divider_ratio, 1'b0};
    // half-unit ratio in high mode loses symmetry by one quarter period
    assign div_lim    = (freq_mode_high && ratio_q4[1]) ? (ratio_q4 >> 1) + (RW+1)'(1) : ratio_q4 >> 1;

    // ----------------------------------------
    // timebase and fine shift
    // ----------------------------------------
    always_comb begin
        phase_d = phase_q;
        qcnt_d  = qcnt_q;
        pcnt_d  = pcnt_q;
        acc_d   = (acc_sum >= synth_len) ? acc_sum - synth_len : acc_sum;
        fine_d  = fine_q;
        if (rise || !valid || phase_q + PW'(1) >= per) begin
            phase_d = '0;
        end else begin
            phase_d = phase_q + PW'(1);
        end
        if (qtick) begin
            qcnt_d = (qcnt_q + (RW+1)'(1) >= ratio_q4) ? '0 : qcnt_q + (RW+1)'(1);
        end
        // realign the synthesizer to the zero edge every divide-count input periods
        if (valid && eff == '0) begin
            pcnt_d = (pcnt_q + RW'(1) >= dvs) ? '0 : pcnt_q + RW'(1);
            if (pcnt_q + RW'(1) >= dvs) begin
                acc_d = '0;
            end
        end
        if (fine_step_req) begin
            if (fine_step_inc && fine_q < ccp_fine_t'(`CCP_FINE_MAX)) begin
                fine_d = fine_q + ccp_fine_t'(1);
            end else if (!fine_step_inc && fine_q > -ccp_fine_t'(`CCP_FINE_MAX)) begin
                fine_d = fine_q - ccp_fine_t'(1);
            end
        end
    end

    // ----------------------------------------
    // output waveforms
    // ----------------------------------------
    always_comb begin
        outs_d    = '0;
        outs_d[0] = valid && (eff < lim);
        outs_d[1] = valid && !freq_mode_high && (sub_mod(eff, qtr, per) < lim);
        outs_d[2] = valid && (sub_mod(eff, half, per) < lim);
        outs_d[3] = valid && !freq_mode_high && (sub_mod(eff, tqtr, per) < lim);
        outs_d[4] = valid && !freq_mode_high && (eff2 < qtr);
        outs_d[5] = valid && !freq_mode_high && (eff2 >= qtr);
        outs_d[6] = valid && (qcnt_q < div_lim);
        // synthesized rate is limited to half the core clock by this sampling
        outs_d[7] = valid && (acc_q < (synth_len >> 1));
        outs_d[8] = valid && (acc_q >= (synth_len >> 1));
    end

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            phase_q <= '0;
            qcnt_q  <= '0;
            pcnt_q  <= '0;
            acc_q   <= '0;
            fine_q  <= ccp_fine_t'(FINE_FIXED);
            outs_q  <= '0;
            valid_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            qcnt_q  <= qcnt_d;
            pcnt_q  <= pcnt_d;
            acc_q   <= acc_d;
            fine_q  <= fine_d;
            outs_q  <= outs_d;
            valid_q <= valid;
        end
    end

    assign deskewed_out_phase_zero    = outs_q[0];
    assign quadrant_out_quarter       = outs_q[1];
    assign quadrant_out_half          = outs_q[2];
    assign quadrant_out_three_quarter = outs_q[3];
    assign doubled_out                = outs_q[4];
    assign doubled_out_inverted_phase = outs_q[5];
    assign divided_out                = outs_q[6];
    assign synth_out                  = outs_q[7];
    assign synth_out_inverted_phase   = outs_q[8];
    assign fine_shift_value           = fine_q;
    assign measure_valid              = valid_q;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_fine_up;
        fine_step_req && fine_step_inc && fine_q < ccp_fine_t'(`CCP_FINE_MAX);
    endsequence

    // a fine step, a new period or a new high time may move an edge by more than one cycle
    sequence s_steady;
        $past(valid, 2) && $past(per) == $past(per, 2) && $past(lim) == $past(lim, 2) &&
        $past(fine_q) == $past(fine_q, 2);
    endsequence

    a_quad_high_off: assert property (freq_mode_high |=> !quadrant_out_quarter && !quadrant_out_three_quarter)
        else $error("quarter outputs active in high mode");
    a_dbl_high_off: assert property (freq_mode_high |=> !doubled_out && !doubled_out_inverted_phase)
        else $error("doubled outputs active in high mode");
    a_zero_rise_at: assert property (s_steady ##0 $rose(deskewed_out_phase_zero) |-> $past(eff) == '0)
        else $error("zero output rose away from phase zero");
    a_quarter_lag: assert property (s_steady ##0 (!$past(freq_mode_high, 2) && $rose(quadrant_out_quarter))
                                    |-> $past(eff) == $past(qtr))
        else $error("quarter output not a quarter period late");
    a_pair_compl: assert property (valid && duty_correct_en && !per[0] |=>
                                   deskewed_out_phase_zero != quadrant_out_half)
        else $error("zero and half outputs not complementary");
    a_synth_pair: assert property (valid |=> synth_out != synth_out_inverted_phase)
        else $error("synth pair not complementary");
    a_dbl_pair: assert property (valid && !freq_mode_high |=> doubled_out != doubled_out_inverted_phase)
        else $error("doubled pair not complementary");
    a_fine_step_up: assert property (s_fine_up |=> fine_q == $past(fine_q) + ccp_fine_t'(1))
        else $error("fine shift did not step up");
    a_fine_bounded: assert property (fine_q <= ccp_fine_t'(`CCP_FINE_MAX) &&
                                     fine_q >= -ccp_fine_t'(`CCP_FINE_MAX))
        else $error("fine shift out of range");
    a_idle_quiet: assert property (!valid |=> !deskewed_out_phase_zero && !synth_out && !divided_out)
        else $error("outputs toggle before the period is known");
endmodule

// [test/ccp_ddr_partner.sv]
// model of the source clock and of the DDR flip-flops fed by the derived outputs
`timescale 1ns/1ps
module ccp_ddr_partner (
    input  wire logic        core_clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  src_period,
    input  wire logic [7:0]  src_high,
    input  wire logic        deskewed_out_phase_zero,
    input  wire logic        quadrant_out_half,
    output logic             source_clock_in,
    output logic [15:0]      ddr_c0_edges,
    output logic [15:0]      ddr_c1_edges
);
    logic [7:0] cnt_q = 8'h00;

    // ----------------------------------------
    // source oscillator
    // ----------------------------------------
    // launched on the falling edge so it never races the sampling edge
    always @(negedge core_clk) begin
        cnt_q <= (cnt_q >= src_period - 8'h01) ? 8'h00 : cnt_q + 8'h01;
    end
    assign source_clock_in = (cnt_q < src_high);

    // ----------------------------------------
    // DDR output flip-flop clocks
    // ----------------------------------------
    always @(posedge deskewed_out_phase_zero or negedge rst_n) begin
        if (!rst_n)
            ddr_c0_edges <= 16'h0000;
        else
            ddr_c0_edges <= ddr_c0_edges + 16'h0001;
    end
    // second phase from the companion, not a local inversion: less distortion
    always @(posedge quadrant_out_half or negedge rst_n) begin
        if (!rst_n)
            ddr_c1_edges <= 16'h0000;
        else
            ddr_c1_edges <= ddr_c1_edges + 16'h0001;
    end
endmodule

// [test/ccp_clock_outputs_tb.sv]
// self-checking bench of the derived clock output stage
`timescale 1ns/1ps
module ccp_clock_outputs_tb;
    import ccp_pkg::*;
    logic        core_clk = 1'b0;
    logic        rst_n    = 1'b1;
    logic        dcc      = 1'b1;
    logic        fhigh    = 1'b0;
    logic        step_req = 1'b0;
    logic        step_inc = 1'b0;
    logic [4:0]  ratio    = 5'h04;
    logic [4:0]  mult     = 5'h01;
    logic [4:0]  div      = 5'h01;
    logic [7:0]  per      = 8'h08;
    logic [7:0]  hi_t     = 8'h03;
    wire  [9:0]  o;
    logic        mvalid;
    logic [15:0] c0, c1, s0, s1;
    ccp_fine_t   fine;
    logic [31:0] seed = 32'h00014f17;
    int failures = 0, total_checks = 0;
    int hi[10], ri[10], fr[10];
    int L, P, H, R, M, D, base0, base4;

    always #2.5 core_clk = ~core_clk;

    ccp_clock_outputs #(.FINE_FIXED(0)) u_ccp_clock_outputs (
        .core_clk(core_clk), .rst_n(rst_n), .source_clock_in(o[9]), .duty_correct_en(dcc),
        .freq_mode_high(fhigh), .divider_ratio(ratio), .synth_mult(mult), .synth_div(div),
        .fine_step_req(step_req), .fine_step_inc(step_inc), .deskewed_out_phase_zero(o[0]),
        .quadrant_out_quarter(o[1]), .quadrant_out_half(o[2]), .quadrant_out_three_quarter(o[3]),
        .doubled_out(o[4]), .doubled_out_inverted_phase(o[5]), .divided_out(o[6]), .synth_out(o[7]),
        .synth_out_inverted_phase(o[8]), .fine_shift_value(fine), .measure_valid(mvalid));

    ccp_ddr_partner u_ccp_ddr_partner (
        .core_clk(core_clk), .rst_n(rst_n), .src_period(per), .src_high(hi_t),
        .deskewed_out_phase_zero(o[0]), .quadrant_out_half(o[2]), .source_clock_in(o[9]),
        .ddr_c0_edges(c0), .ddr_c1_edges(c1));

    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    function automatic int md(input int a, input int m);
        return ((a % m) + m) % m;
    endfunction

    function automatic int want_hi(input int i);
        int q;
        q = dcc ? L / 2 : (L / P) * H;
        case (i)
            0, 2: return q;
            1, 3: return fhigh ? 0 : q;
            4, 5: return fhigh ? 0 : L / 2;
            6: return (fhigh && R % 2 == 1) ? L * (R + 1) / (2 * R) : L / 2;
            default: return L / 2;
        endcase
    endfunction

    function automatic int want_ri(input int i);
        case (i)
            0, 2: return L / P;
            1, 3: return fhigh ? 0 : L / P;
            4, 5: return fhigh ? 0 : 2 * L / P;
            6: return 2 * L / (R * P);
            default: return L * M / (P * D);
        endcase
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        total_checks++;
        if (seen !== want) begin
            failures++;
            $display("unexpected value at %0t: seen %h expected %h", $time, seen, want);
        end
    endtask

    task automatic print_verdict();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // synth case k: 0 -> 1/1, 1 -> 2/1, 2 -> 3/2 (all keep an exact half duty)
    task automatic apply(input int p, input int h, input logic dc, input logic fh, input int r, input int k);
        P = p;
        H = h;
        R = r;
        M = (k == 2) ? 3 : k + 1;
        D = (k == 2) ? 2 : 1;
        per = 8'(p);
        hi_t = 8'(h);
        dcc = dc;
        fhigh = fh;
        ratio = 5'(r);
        mult = 5'(M);
        div = 5'(D);
    endtask

    task automatic run_case();
        logic [9:0] prev;
        L = 24 * P;
        repeat (6 * P + 12) @(negedge core_clk);
        for (int i = 0; i < 10; i++) begin
            hi[i] = 0;
            ri[i] = 0;
            fr[i] = -1;
        end
        prev = o;
        s0 = c0;
        s1 = c1;
        for (int n = 0; n < L; n++) begin
            @(negedge core_clk);
            for (int i = 0; i < 10; i++) begin
                if (o[i] === 1'b1) hi[i]++;
                if (o[i] === 1'b1 && prev[i] === 1'b0) ri[i]++;
                if (o[i] === 1'b1 && prev[i] === 1'b0 && fr[i] < 0) fr[i] = n;
            end
            prev = o;
        end
        for (int i = 0; i < 9; i++) begin
            check(hi[i], want_hi(i));
            check(ri[i], want_ri(i));
        end
        check(md(fr[2] - fr[0], P), P / 2);
        check(32'(c1 - s1), 32'(c0 - s0));
        check(32'(c0 - s0), 32'(L / P));
        if (!fhigh) begin
            check(md(fr[1] - fr[0], P), P / 4);
            check(md(fr[3] - fr[0], P), 3 * P / 4);
            check(md(fr[5] - fr[4], P / 2), P / 4);
        end
    endtask

    // back-to-back steps, called on a falling edge
    task automatic step(input logic up, input int n);
        for (int k = 0; k < n; k++) begin
            step_req = 1'b1;
            step_inc = up;
            @(negedge core_clk);
        end
        step_req = 1'b0;
        @(negedge core_clk);
    endtask

    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        // a real falling edge of reset, so the edge counters of the partner start from zero
        #1 rst_n = 1'b0;
        repeat (6) @(negedge core_clk);
        rst_n = 1'b1;
        check({{23{fine[8]}}, fine}, 32'h00000000);
        apply(8, 3, 1'b1, 1'b0, 4, 0);
        run_case();
        check(mvalid, 1'b1);
        apply(8, 3, 1'b0, 1'b0, 3, 1);
        run_case();
        apply(12, 5, 1'b1, 1'b1, 3, 2);
        run_case();
        apply(16, 4, 1'b0, 1'b1, 4, 1);
        run_case();
        for (int j = 0; j < 6; j++) begin
            seed = xs(seed);
            apply(8 + 4 * int'(seed % 5), 1 + int'(seed[15:8]) % 7, seed[16], seed[17],
                  2 + int'(seed[23:18]) % 3, int'(seed[31:24]) % 3);
            run_case();
        end
        // zero multiply and divide codes act as one, a ratio code below two as two
        apply(8, 3, 1'b1, 1'b0, 2, 0);
        mult  = 5'h00;
        div   = 5'h00;
        ratio = 5'h01;
        run_case();
        apply(8, 2, 1'b1, 1'b0, 2, 1);
        run_case();
        base0 = md(fr[0] - fr[9], 8);
        base4 = md(fr[4] - fr[9], 4);
        step(1'b1, 32);
        check({{23{fine[8]}}, fine}, 32'h00000020);
        run_case();
        check(md(fr[0] - fr[9], 8), md(base0 + 1, 8));
        check(md(fr[4] - fr[9], 4), md(base4 + 1, 4));
        step(1'b1, 300);
        check({{23{fine[8]}}, fine}, 32'h000000ff);
        step(1'b0, 600);
        check({{23{fine[8]}}, fine}, 32'hffffff01);
        print_verdict();
    end

    // whole plan is under 10000 cycles; four times that means a hang
    initial begin
        #200000;
        failures++;
        print_verdict();
    end
endmodule
